// file: scsp_defines.svh
// Constants for the clock-stop SPI serial port
`ifndef SCSP_DEFINES_SVH
`define SCSP_DEFINES_SVH
`define SCSP_WORD_BITS 16
`define SCSP_CNT_BITS 5
`define SCSP_DIV_BITS 8
`define SCSP_FIFO_DEPTH 16
`define SCSP_SLAVE_DIV 8'h01
`define SCSP_SLAVE_SRC 1'b1
`define SCSP_FS_POL 1'b1
`define SCSP_STOP_LATE 2'h2
`define SCSP_STOP_EARLY 2'h3
`define SCSP_CLK_POL 1'b1
`endif

// file: scsp_pkg.sv
// Types for the clock-stop SPI serial port
package scsp_pkg;
    typedef enum logic [3:0] {
        SCSP_IDLE = 4'h1,
        SCSP_SEL = 4'h2,
        SCSP_SHIFT = 4'h4,
        SCSP_DONE = 4'h8
    } scsp_state_t;
    typedef logic [15:0] scsp_word_t;
endpackage : scsp_pkg

// file: scsp_fifo_if.sv
// Stream handshake carrier between port and FIFO
`timescale 1ns/100ps
`default_nettype none
interface scsp_fifo_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : scsp_fifo_if
`default_nettype wire

// file: scsp_fifo.sv
// Flop based FIFO with valid/ready both sides
`timescale 1ns/100ps
`default_nettype none
module scsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    scsp_fifo_if.snk wr,
    scsp_fifo_if.src rd
);
    import scsp_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;
    assign wr.ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign rd.valid = wp_q != rp_q;
    assign rd.data = mem_q[rp_q[AW-1:0]];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp_q <= '0;
        end else if (clk_en && push) begin
            wp_q <= wp_q + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rp_q <= '0;
        end else if (clk_en && pop) begin
            rp_q <= rp_q + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
        end
    end
endmodule : scsp_fifo
`default_nettype wire

// file: scsp_sync.sv
// Three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module scsp_sync #(
    parameter int N = 3,
    parameter logic [2:0] INIT = 3'h0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [N-1:0] pin_in,
    output var logic [N-1:0] pin_out
);
    import scsp_pkg::*;
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    genvar i;
    for (i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                s1_q[i] <= INIT[i];
                s2_q[i] <= INIT[i];
                s3_q[i] <= INIT[i];
                pin_out[i] <= INIT[i];
            end else if (clk_en) begin
                s1_q[i] <= pin_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    pin_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : scsp_sync
`default_nettype wire

// file: scsp_port.sv
// Clock-stop SPI serial port, master or slave, clock polarity one
`timescale 1ns/100ps
`default_nettype none
`include "scsp_defines.svh"
module scsp_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic master_mode,
    input wire logic [1:0] clock_stop_select,
    input wire logic [7:0] sample_clock_divider,
    input wire scsp_pkg::scsp_word_t tx_data,
    input wire logic tx_valid,
    output var logic tx_ready,
    output var scsp_pkg::scsp_word_t rx_data,
    output var logic rx_valid,
    output var logic busy,
    output var logic tx_clock_polarity,
    output var logic tx_frame_polarity,
    output var logic rx_frame_polarity,
    output var logic sample_clock_source,
    output var logic [7:0] sample_clock_eff,
    output var logic tx_clock_dir,
    output var logic rx_clock_dir,
    output var logic tx_frame_dir,
    output var logic rx_frame_dir,
    input wire logic tx_shift_clock_pin_i,
    output var logic tx_shift_clock_pin_o,
    output var logic tx_shift_clock_pin_oe,
    input wire logic tx_frame_pin_i,
    output var logic tx_frame_pin_o,
    output var logic tx_frame_pin_oe,
    input wire logic rx_frame_pin_i,
    input wire logic serial_rx_pin,
    output var logic serial_tx_pin_o,
    output var logic serial_tx_pin_oe
);
    import scsp_pkg::*;

    scsp_fifo_if f_in();
    scsp_state_t st_q;
    logic [7:0] cnt_q;
    logic [`SCSP_CNT_BITS-1:0] bit_q;
    scsp_word_t sh_q;
    logic late;
    logic [7:0] div;
    logic [7:0] hi_len;
    logic [7:0] lo_len;
    logic [2:0] pins_s;
    logic sclk_s;
    logic sclk_p_q;
    logic sel_int;
    logic sel_p_q;
    logic rise;
    logic fall;
    logic s_sample;
    logic s_change;
    logic [`SCSP_CNT_BITS-1:0] occ_q;
    logic [`SCSP_CNT_BITS-1:0] occ_d;

    // Only words that the registered ready has promised are taken
    assign f_in.valid = tx_valid && tx_ready;
    assign f_in.data = tx_data;
    scsp_fifo_if f_out();
    scsp_fifo #(.WIDTH(`SCSP_WORD_BITS), .DEPTH(`SCSP_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .wr(f_in.snk),
        .rd(f_out.src)
    );

    // Clock idles high, selects idle high
    scsp_sync #(.N(3), .INIT(3'h7)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin_in({tx_shift_clock_pin_i, tx_frame_pin_i, rx_frame_pin_i}),
        .pin_out(pins_s)
    );
    assign sclk_s = pins_s[2];
    // Either select pin low enables the slave
    assign sel_int = ~(pins_s[1] & pins_s[0]);
    assign late = clock_stop_select == `SCSP_STOP_LATE;
    // Slave always runs the sample clock at CPU/2
    assign div = master_mode ? sample_clock_divider : `SCSP_SLAVE_DIV;
    assign hi_len = (div == 8'h00 || div[0]) ? 8'((9'(div) + 9'h001) >> 1)
                                            : 8'((div >> 1) + 8'h01);
    assign lo_len = (div == 8'h00 || div[0]) ? 8'((9'(div) + 9'h001) >> 1)
                                            : 8'(div >> 1);
    assign rise = sclk_s && !sclk_p_q;
    assign fall = !sclk_s && sclk_p_q;
    assign s_sample = late ? rise : fall;
    assign s_change = late ? fall : rise;
    assign f_out.ready = (st_q == SCSP_IDLE) && (master_mode || (sel_int && !sel_p_q));
    // Ready is registered, so it must look one push ahead or a word is lost
    assign occ_d = occ_q + 5'(f_in.valid && f_in.ready) - 5'(f_out.valid && f_out.ready);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            occ_q <= '0;
        end else if (clk_en) begin
            occ_q <= occ_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_clock_polarity <= `SCSP_CLK_POL;
            tx_frame_polarity <= `SCSP_FS_POL;
            rx_frame_polarity <= `SCSP_FS_POL;
            sample_clock_source <= `SCSP_SLAVE_SRC;
            sample_clock_eff <= `SCSP_SLAVE_DIV;
            tx_clock_dir <= 1'b0;
            tx_frame_dir <= 1'b0;
            rx_clock_dir <= 1'b0;
            rx_frame_dir <= 1'b0;
            tx_ready <= 1'b0;
        end else if (clk_en) begin
            tx_frame_polarity <= `SCSP_FS_POL;
            rx_frame_polarity <= `SCSP_FS_POL;
            sample_clock_source <= `SCSP_SLAVE_SRC;
            sample_clock_eff <= div;
            tx_clock_dir <= master_mode;
            tx_frame_dir <= master_mode;
            rx_clock_dir <= 1'b0;
            rx_frame_dir <= 1'b0;
            tx_ready <= occ_d != 5'(`SCSP_FIFO_DEPTH);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclk_p_q <= 1'b1;
            sel_p_q <= 1'b0;
        end else if (clk_en) begin
            sclk_p_q <= sclk_s;
            sel_p_q <= sel_int;
        end
    end

    // Master sequencer; counts are in CPU cycles (2P each)
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q <= SCSP_IDLE;
            cnt_q <= 8'h00;
            bit_q <= '0;
            sh_q <= '0;
            busy <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= '0;
            tx_shift_clock_pin_o <= `SCSP_CLK_POL;
            tx_shift_clock_pin_oe <= 1'b0;
            tx_frame_pin_o <= 1'b1;
            tx_frame_pin_oe <= 1'b0;
            serial_tx_pin_o <= 1'b0;
            serial_tx_pin_oe <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= 1'b0;
            tx_shift_clock_pin_oe <= master_mode;
            tx_frame_pin_oe <= master_mode;
            if (master_mode) begin
                case (st_q)
                    SCSP_IDLE: begin
                        tx_shift_clock_pin_o <= `SCSP_CLK_POL;
                        tx_frame_pin_o <= 1'b1;
                        if (f_out.valid) begin
                            sh_q <= f_out.data;
                            busy <= 1'b1;
                            tx_frame_pin_o <= 1'b0;
                            serial_tx_pin_oe <= 1'b1;
                            serial_tx_pin_o <= f_out.data[15];
                            cnt_q <= late ? hi_len : 8'h01;
                            bit_q <= '0;
                            st_q <= SCSP_SEL;
                        end
                    end
                    SCSP_SEL: begin
                        // Select leads the first clock edge by one high phase in 10b, by one cycle in 11b
                        if (cnt_q <= 8'h01) begin
                            tx_shift_clock_pin_o <= 1'b0;
                            cnt_q <= lo_len;
                            st_q <= SCSP_SHIFT;
                            // First falling edge already samples in 11b
                            if (!late) begin
                                sh_q <= {sh_q[14:0], serial_rx_pin};
                            end
                        end else begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                    SCSP_SHIFT: begin
                        if (cnt_q > 8'h01) begin
                            cnt_q <= cnt_q - 8'h01;
                        end else if (!tx_shift_clock_pin_o) begin
                            tx_shift_clock_pin_o <= 1'b1;
                            cnt_q <= hi_len;
                            if (late) begin
                                sh_q <= {sh_q[14:0], serial_rx_pin};
                            end else begin
                                serial_tx_pin_o <= sh_q[15];
                            end
                        end else begin
                            cnt_q <= lo_len;
                            bit_q <= bit_q + 5'h01;
                            if (late) begin
                                serial_tx_pin_o <= sh_q[15];
                            end else if (bit_q != 5'h0f) begin
                                sh_q <= {sh_q[14:0], serial_rx_pin};
                            end
                            // Sixteenth high phase ends the word with no falling edge
                            if (bit_q == 5'h0f) begin
                                st_q <= SCSP_DONE;
                                tx_shift_clock_pin_o <= 1'b1;
                            end else begin
                                tx_shift_clock_pin_o <= 1'b0;
                            end
                        end
                    end
                    SCSP_DONE: begin
                        tx_shift_clock_pin_o <= `SCSP_CLK_POL;
                        tx_frame_pin_o <= 1'b1;
                        serial_tx_pin_oe <= 1'b0;
                        rx_data <= sh_q;
                        rx_valid <= 1'b1;
                        busy <= 1'b0;
                        st_q <= SCSP_IDLE;
                    end
                    default: st_q <= SCSP_IDLE;
                endcase
            end else begin
                // Slave: timing set by the external master
                st_q <= SCSP_IDLE;
                tx_frame_pin_o <= 1'b1;
                if (sel_int && !sel_p_q) begin
                    busy <= 1'b1;
                    bit_q <= '0;
                    sh_q <= f_out.valid ? f_out.data : '0;
                    serial_tx_pin_o <= f_out.valid ? f_out.data[15] : 1'b0;
                    serial_tx_pin_oe <= 1'b1;
                end else if (!sel_int) begin
                    serial_tx_pin_oe <= 1'b0;
                    busy <= 1'b0;
                end else begin
                    if (s_sample) begin
                        sh_q <= {sh_q[14:0], serial_rx_pin};
                        bit_q <= bit_q + 5'h01;
                        if (bit_q == 5'h0f) begin
                            rx_data <= {sh_q[14:0], serial_rx_pin};
                            rx_valid <= 1'b1;
                        end
                    end
                    if (s_change && bit_q != '0) begin
                        serial_tx_pin_o <= sh_q[15];
                    end
                end
            end
        end
    end

    property p_slave_release;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !master_mode && !sel_int && !$past(master_mode)) |=> !serial_tx_pin_oe;
    endproperty
    a_slave_release: assert property (p_slave_release) else $error("data pin not released");

    property p_slave_divider;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !master_mode) |=> sample_clock_eff == `SCSP_SLAVE_DIV;
    endproperty
    a_slave_divider: assert property (p_slave_divider) else $error("slave divider not one");

    property p_idle_clock;
        @(posedge sys_clk) disable iff (!resetn)
        (master_mode && st_q == SCSP_IDLE && $past(st_q) == SCSP_IDLE) |-> tx_shift_clock_pin_o;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock toggles while idle");

    sequence s_start;
        clk_en && master_mode && st_q == SCSP_IDLE && f_out.valid;
    endsequence
    property p_select_first;
        @(posedge sys_clk) disable iff (!resetn)
        s_start |=> !tx_frame_pin_o && tx_shift_clock_pin_o;
    endproperty
    a_select_first: assert property (p_select_first) else $error("select not before clock");

    property p_dirs;
        @(posedge sys_clk) disable iff (!resetn)
        clk_en |=> (tx_clock_dir == $past(master_mode)) && !rx_clock_dir && !rx_frame_dir;
    endproperty
    a_dirs: assert property (p_dirs) else $error("pin directions wrong");

    property p_first_bit;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !master_mode && sel_int && !sel_p_q) |=> serial_tx_pin_oe;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit not driven");

    property p_polarity;
        @(posedge sys_clk) disable iff (!resetn)
        ##1 (tx_frame_polarity && rx_frame_polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("frame polarity not one");

    property p_select_inv;
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !master_mode && !(pins_s[1] && pins_s[0]) && !sel_p_q) |=> busy && serial_tx_pin_oe;
    endproperty
    a_select_inv: assert property (p_select_inv) else $error("select not inverted");
endmodule : scsp_port
`default_nettype wire

// file: scsp_far.sv
// Far-side SPI partner: slave to a master port, master to a slave port
`timescale 1ns/100ps
`default_nettype none
module scsp_far (
    input wire logic sys_clk,
    input wire logic as_master,
    input wire logic mode11,
    input wire logic dev_clk,
    input wire logic dev_sel_n,
    input wire logic dev_oe,
    input wire logic dev_dout,
    output var logic clk_o,
    output var logic sel_tx_n,
    output var logic sel_rx_n,
    output var logic dout
);
    // Slave port synchronises pins, so phases stay well above four cycles
    localparam int PH = 8;
    logic [15:0] rep_q[$];
    logic [15:0] cap_q[$];
    logic [15:0] sh;
    logic [15:0] cap;
    logic idle_q;
    logic m_d;
    logic line;
    int n;
    initial begin
        clk_o = 1'b1;
        sel_tx_n = 1'b1;
        sel_rx_n = 1'b1;
        m_d = 1'b0;
        idle_q = 1'b0;
        sh = '0;
        cap = '0;
        n = 0;
    end
    // Released lines toggle so a stale value never passes as data
    always @(posedge sys_clk) idle_q <= ~idle_q;
    assign line = dev_oe ? dev_dout : ~idle_q;
    always @* dout = as_master ? m_d : (dev_sel_n ? idle_q : sh[15]);
    always @(negedge dev_sel_n) if (!as_master) begin
        sh = (rep_q.size() > 0) ? rep_q.pop_front() : 16'h0;
        n = 0;
    end
    always @(dev_clk) if (!as_master && !dev_sel_n) begin
        if (dev_clk ^ mode11) begin
            cap = {cap[14:0], line};
            n++;
            if (n == 16) cap_q.push_back(cap);
        end else if (n > 0) sh = sh << 1;
    end
    task automatic xfer(input logic [15:0] w, input logic use_rx, output logic [15:0] got,
                        output logic [1:0] fb, output logic rel);
        got = '0;
        @(posedge sys_clk);
        #1;
        m_d = w[15];
        if (use_rx) sel_rx_n = 1'b0;
        else sel_tx_n = 1'b0;
        repeat (PH) @(posedge sys_clk);
        fb = {dev_oe, dev_dout};
        for (int i = 15; i >= 0; i--) begin
            #1 clk_o = 1'b0;
            if (mode11) got[i] = line;
            else m_d = w[i];
            repeat (PH) @(posedge sys_clk);
            #1 clk_o = 1'b1;
            if (!mode11) got[i] = line;
            else m_d = (i > 0) ? w[i-1] : ~w[0];
            repeat (PH) @(posedge sys_clk);
        end
        #1 sel_rx_n = 1'b1;
        sel_tx_n = 1'b1;
        m_d = ~m_d;
        repeat (PH) @(posedge sys_clk);
        rel = dev_oe;
    endtask : xfer
endmodule : scsp_far
`default_nettype wire

// file: scsp_port_tb_top.sv
// Self-checking bench for the clock-stop SPI port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module scsp_port_tb_top;
    import scsp_pkg::*;
    logic sys_clk, resetn, clk_en, master_mode, tx_valid, tx_ready, rx_valid, busy;
    logic [1:0] clock_stop_select;
    logic [7:0] sample_clock_divider, sample_clock_eff, cfg;
    scsp_word_t tx_data, rx_data, ew;
    logic cp, fp, rp, src, cd, rcd, fd, rfd;
    logic sck_o, sck_oe, fs_o, fs_oe, dx_o, dx_oe, far_sck, far_fs, far_fr, far_dx, sck_w, fs_w, pclk, lo_seen;
    int errors, compares, cyc, run, hi_e, lo_e;
    scsp_word_t exp_tx[$];
    scsp_word_t exp_rx[$];
    assign cfg = {cp, fp, rp, src, cd, rcd, fd, rfd};
    assign sck_w = sck_oe ? sck_o : far_sck;
    assign fs_w = fs_oe ? fs_o : far_fs;
    scsp_port uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .master_mode(master_mode),
        .clock_stop_select(clock_stop_select), .sample_clock_divider(sample_clock_divider),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .busy(busy), .tx_clock_polarity(cp), .tx_frame_polarity(fp),
        .rx_frame_polarity(rp), .sample_clock_source(src), .sample_clock_eff(sample_clock_eff),
        .tx_clock_dir(cd), .rx_clock_dir(rcd), .tx_frame_dir(fd), .rx_frame_dir(rfd),
        .tx_shift_clock_pin_i(sck_w), .tx_shift_clock_pin_o(sck_o), .tx_shift_clock_pin_oe(sck_oe),
        .tx_frame_pin_i(fs_w), .tx_frame_pin_o(fs_o), .tx_frame_pin_oe(fs_oe), .rx_frame_pin_i(far_fr),
        .serial_rx_pin(far_dx), .serial_tx_pin_o(dx_o), .serial_tx_pin_oe(dx_oe));
    scsp_far far (.sys_clk(sys_clk), .as_master(~master_mode), .mode11(clock_stop_select[0]),
        .dev_clk(sck_w), .dev_sel_n(fs_w), .dev_oe(dx_oe), .dev_dout(dx_o), .clk_o(far_sck),
        .sel_tx_n(far_fs), .sel_rx_n(far_fr), .dout(far_dx));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("Error timeout expected %0d seen %0d", 20000, cyc);
            close_out;
        end
        if (resetn && sck_oe === 1'b1) begin
            if (fs_o === 1'b1) `CHK("idle_clk", 1'b1, sck_o)
            `CHK("busy", ~fs_o, busy)
            if (sck_o !== pclk) begin
                if (!sck_o) `CHK("sel_at_fall", 1'b0, fs_o)
                if (!pclk) `CHK("low_len", lo_e, run)
                else if (lo_seen) `CHK("high_len", hi_e, run)
                lo_seen = lo_seen | !pclk;
                run = 1;
            end else run++;
            if (fs_o) lo_seen = 1'b0;
        end
        pclk = sck_o;
        if (rx_valid === 1'b1) begin
            ew = exp_rx.pop_front();
            `CHK("rx_word", ew, rx_data)
        end
    end
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic close_out;
        $display("Counts: compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic push(input scsp_word_t w);
        int n;
        n = 0;
        tx_data = w;
        tx_valid = 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 50);
        `CHK("push_ready", 1'b1, tx_ready)
        #1;
    endtask : push
    task automatic master_run(input int m, input int d);
        scsp_word_t w, g;
        clock_stop_select = m[1:0];
        sample_clock_divider = d[7:0];
        // Even dividers give the longer half to the high phase
        hi_e = (d % 2) ? (d + 1) / 2 : d / 2 + 1;
        lo_e = (d % 2) ? (d + 1) / 2 : d / 2;
        tick;
        tick;
        `CHK("divider", d[7:0], sample_clock_eff)
        `CHK("config", 8'hfa, cfg)
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            far.rep_q.push_back(w);
            exp_rx.push_back(w);
        end
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            exp_tx.push_back(w);
            push(w);
        end
        tx_valid = 1'b0;
        for (int c = 0; c < 3000 && far.cap_q.size() < 3; c++) tick;
        repeat (20) tick;
        while (exp_tx.size() > 0) begin
            w = exp_tx.pop_front();
            g = far.cap_q.pop_front();
            `CHK("tx_word", w, g)
        end
        `CHK("rx_left", 0, exp_rx.size())
        $display("Test master mode %0d divider %0d done", m, d);
    endtask : master_run
    task automatic slave_run;
        scsp_word_t w, s, got;
        logic [1:0] fb;
        logic rel;
        int n;
        master_mode = 1'b0;
        clock_stop_select = 2'h2;
        repeat (3) tick;
        `CHK("divider", 8'h01, sample_clock_eff)
        `CHK("config", 8'hf0, cfg)
        n = 0;
        for (int c = 0; c < 40; c++) begin
            tx_data = 16'($urandom);
            tx_valid = 1'b1;
            @(posedge sys_clk);
            if (tx_ready === 1'b1) begin
                exp_tx.push_back(tx_data);
                n++;
            end
            #1;
        end
        tx_valid = 1'b0;
        `CHK("fifo_fill", 16, n)
        // Drained past empty: the extra word must come out as zeros
        for (int i = 0; i < 17; i++) begin
            clock_stop_select = {1'b1, i[0]};
            w = (exp_tx.size() > 0) ? exp_tx.pop_front() : 16'h0;
            s = 16'($urandom);
            exp_rx.push_back(s);
            tick;
            far.xfer(s, i[1], got, fb, rel);
            `CHK("tx_word", w, got)
            `CHK("first_bit", {1'b1, w[15]}, fb)
            `CHK("release", 1'b0, rel)
            repeat ($urandom % 20) tick;
        end
        repeat (10) tick;
        `CHK("rx_left", 0, exp_rx.size())
        $display("Test slave done");
    endtask : slave_run
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        master_mode = 1'b1;
        clock_stop_select = 2'h2;
        sample_clock_divider = 8'h01;
        tx_valid = 1'b0;
        tx_data = '0;
        errors = 0;
        compares = 0;
        cyc = 0;
        run = 0;
        pclk = 1'b1;
        lo_seen = 1'b0;
        hi_e = 1;
        lo_e = 1;
        void'($urandom(32'h6671));
        repeat (12) @(posedge sys_clk);
        #1 resetn = 1'b1;
        tick;
        for (int m = 2; m < 4; m++) begin
            for (int d = 1; d < 5; d++) master_run(m, d);
        end
        slave_run;
        close_out;
    end
endmodule : scsp_port_tb_top
`default_nettype wire
